// file: include/sbcc_defines.vh
// Overview of operation
// (R1) master bit rate about overflow rate over 3
// (R2) generated high phase twice the low phase
// (R3) never faster than overflow minimum high/low
// (R4) normal: hold 3 clocks, setup low-4/1
// (R5) extended: setup 11, hold 12 clocks
// (R6) setup delay runs from data write to release
// (R7) timeout timer reloads scl high, counts low
// (R8) software sets 25 ms timeout, re-enables
// (R9) free after both high over 10 overflows
// (R10) bit 7 enables, lines monitored while enabled
// (R11) bit 6 blocks slave interrupts, master unchanged
// (R12) bit 5 busy, cleared by stop/free timeout
// (R13) bit 4 selects extended setup/hold timing
// (R14) two-bit field selects overflow source
// (R15) each master phase lasts one overflow minimum
// (R16) inhibit starts next start; inhibited slaves nack (while disabled, bit 6 takes effect at once)
// (R17) one overflow low, two overflows high
`ifndef SBCC_DEFINES_VH
`define SBCC_DEFINES_VH
`define SBCC_CFG_IDX        8'hc1
`define SBCC_CTL_IDX        8'hc2
`define SBCC_CFG_RST        8'h00
`define SBCC_CTL_RST        8'h00
`define SBCC_EN_BIT         7
`define SBCC_INH_BIT        6
`define SBCC_BUSY_BIT       5
`define SBCC_EXT_BIT        4
`define SBCC_TOE_BIT        3
`define SBCC_FTE_BIT        2
`define SBCC_CS_HI          1
`define SBCC_CS_LO          0
`define SBCC_CTL_RUN_BIT    0
`define SBCC_CTL_DAT_BIT    1
`define SBCC_CTL_STALL_BIT  2
`define SBCC_ST_SCL_BIT     4
`define SBCC_ST_SDA_BIT     5
`define SBCC_ST_PH_BIT      6
`define SBCC_HOLD_NORM      4'd3
`define SBCC_HOLD_EXT       4'd12
`define SBCC_SETUP_NORM     4'd1
`define SBCC_SETUP_EXT      4'd11
`define SBCC_LOW_OVF        2'd1
`define SBCC_HIGH_OVF       2'd2
`define SBCC_FREE_OVF       4'd11
`endif

// file: verilog/sbcc_line_mon.v
`timescale 1ns/100ps
module sbcc_line_mon (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_scl,
  input  wire i_sda,
  output wire o_scl,
  output wire o_sda,
  output wire o_start,
  output wire o_stop,
  output wire o_scl_fall
);
  wire [1:0] raw;
  reg  [1:0] meta_r;
  reg  [1:0] sync_r;
  reg  [1:0] prev_r;
  assign raw = {i_sda, i_scl};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
          prev_r[g] <= 1'b1;
        end else begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
    end
  endgenerate

  assign o_scl      = sync_r[0];
  assign o_sda      = sync_r[1];
  // sda falls / rises while scl high
  assign o_start    = sync_r[0] & prev_r[0] & prev_r[1] & ~sync_r[1];
  assign o_stop     = sync_r[0] & prev_r[0] & ~prev_r[1] & sync_r[1];
  assign o_scl_fall = prev_r[0] & ~sync_r[0];
endmodule // sbcc_line_mon

// file: verilog/sbcc_top.v
`timescale 1ns/100ps
`include "sbcc_defines.vh"
module sbcc_top (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire [9:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  input  wire [3:0]  i_tmr_ovf,
  input  wire        i_scl,
  input  wire        i_sda,
  output reg         o_scl_o,
  output reg         o_scl_oe,
  output reg         o_sda_o,
  output reg         o_sda_oe,
  output reg         o_t3_reload,
  output reg         o_t3_count,
  input  wire        i_slave_evt,
  output reg         o_slave_irq,
  output reg         o_slave_nack
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOW  = 3'b010;
  localparam [2:0] ST_HIGH = 3'b100;

  reg  [7:0] cfg_r;
  reg  [7:0] ctl_r;
  reg        busy_r;
  reg        inh_act_r;
  reg  [2:0] st_r;
  reg  [2:0] st_nxt;
  reg  [1:0] ovf_cnt_r;
  reg  [3:0] hold_cnt_r;
  reg  [3:0] setup_cnt_r;
  reg        hold_done_r;
  reg  [3:0] free_cnt_r;
  reg        data_r;

  wire       scl_s;
  wire       sda_s;
  wire       start_det;
  wire       stop_det;
  wire       scl_fall;
  wire       en;
  wire       ext;
  wire       ovf_sel;
  wire       req;
  wire       acc;
  wire [7:0] idx;
  wire       idx_ok;
  wire       hit_cfg;
  wire       hit_ctl;
  wire       free_to;
  wire [3:0] hold_min;
  wire [3:0] setup_min;
  wire       low_done;
  wire       high_done;

  sbcc_line_mon u_mon (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_scl      (scl_s),
    .o_sda      (sda_s),
    .o_start    (start_det),
    .o_stop     (stop_det),
    .o_scl_fall (scl_fall)
  );

  assign en        = cfg_r[`SBCC_EN_BIT];
  assign ext       = cfg_r[`SBCC_EXT_BIT]; // (R13)
  assign ovf_sel   = i_tmr_ovf[cfg_r[`SBCC_CS_HI:`SBCC_CS_LO]]; // (R14)
  assign hold_min  = ext ? `SBCC_HOLD_EXT : `SBCC_HOLD_NORM; // (R4) (R5)
  assign setup_min = ext ? `SBCC_SETUP_EXT : `SBCC_SETUP_NORM; // (R4) (R5)

  // avalon slave: one wait cycle, answer at second edge
  assign req     = i_avs_read | i_avs_write;
  assign acc     = req & ~o_avs_waitrequest;
  assign idx     = i_avs_address[9:2];
  assign idx_ok  = (i_avs_address[1:0] == 2'b00);
  assign hit_cfg = idx_ok & (idx == `SBCC_CFG_IDX);
  assign hit_ctl = idx_ok & (idx == `SBCC_CTL_IDX);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= ~(req & o_avs_waitrequest);
      if (req & o_avs_waitrequest) begin
        if (hit_cfg) begin
          o_avs_readdata <= {24'h00_0000, cfg_r[7:6], busy_r, cfg_r[4:0]}; // (R12)
        end else if (hit_ctl) begin
          o_avs_readdata <= {24'h00_0000, 1'b0, (st_r == ST_HIGH), sda_s, scl_s, 1'b0, ctl_r[2:0]};
        end else begin
          o_avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // config and control registers
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= `SBCC_CFG_RST;
      ctl_r <= `SBCC_CTL_RST;
    end else if (acc & i_avs_write) begin
      if (hit_cfg) begin
        cfg_r <= {i_avs_writedata[7:6], 1'b0, i_avs_writedata[4:0]};
      end
      if (hit_ctl) begin
        ctl_r <= {5'h00, i_avs_writedata[2:0]};
      end
    end
  end

  // busy and free timeout
  assign free_to = cfg_r[`SBCC_FTE_BIT] & (free_cnt_r == `SBCC_FREE_OVF); // (R9)

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      free_cnt_r <= 4'h0;
      busy_r     <= 1'b0;
      inh_act_r  <= 1'b0;
    end else if (!en) begin
      free_cnt_r <= 4'h0;
      busy_r     <= 1'b0;
      inh_act_r  <= cfg_r[`SBCC_INH_BIT];
    end else begin
      if (!(scl_s & sda_s)) begin
        free_cnt_r <= 4'h0;
      end else if (ovf_sel && free_cnt_r != `SBCC_FREE_OVF) begin
        free_cnt_r <= free_cnt_r + 4'h1; // (R9)
      end
      if (start_det) begin
        busy_r    <= 1'b1; // (R12)
        inh_act_r <= cfg_r[`SBCC_INH_BIT]; // (R16)
      end else if (stop_det | free_to) begin
        busy_r <= 1'b0; // (R12)
      end
    end
  end

  // slave gating, timeout timer control
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_slave_irq  <= 1'b0;
      o_slave_nack <= 1'b0;
      o_t3_reload  <= 1'b0;
      o_t3_count   <= 1'b0;
    end else begin
      o_slave_irq  <= en & i_slave_evt & ~inh_act_r; // (R11)
      o_slave_nack <= en & inh_act_r; // (R16)
      o_t3_reload  <= en & cfg_r[`SBCC_TOE_BIT] & scl_s; // (R7)
      o_t3_count   <= en & cfg_r[`SBCC_TOE_BIT] & ~scl_s; // (R7)
    end
  end

  // master clock generator
  assign low_done  = (ovf_cnt_r >= `SBCC_LOW_OVF) & hold_done_r &
                     (setup_cnt_r >= setup_min) & ~ctl_r[`SBCC_CTL_STALL_BIT]; // (R15) (R6)
  assign high_done = (ovf_cnt_r == `SBCC_HIGH_OVF); // (R17) (R2)

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (en & ctl_r[`SBCC_CTL_RUN_BIT]) begin
          st_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (!(en & ctl_r[`SBCC_CTL_RUN_BIT])) begin
          st_nxt = ST_IDLE;
        end else if (low_done) begin
          st_nxt = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (!(en & ctl_r[`SBCC_CTL_RUN_BIT])) begin
          st_nxt = ST_IDLE;
        end else if (high_done | scl_fall) begin
          st_nxt = ST_LOW; // (R3)
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r      <= ST_IDLE;
      ovf_cnt_r <= 2'd0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        ovf_cnt_r <= 2'd0;
      end else if (st_r == ST_HIGH && !scl_s) begin
        ovf_cnt_r <= 2'd0; // (R3)
      end else if (ovf_sel && ovf_cnt_r != `SBCC_HIGH_OVF) begin
        ovf_cnt_r <= ovf_cnt_r + 2'd1; // (R17) (R1)
      end
    end
  end

  // sda hold after fall, setup before rise
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_cnt_r  <= 4'h0;
      hold_done_r <= 1'b0;
      setup_cnt_r <= 4'h0;
      data_r      <= 1'b1;
    end else if (st_nxt == ST_IDLE) begin
      hold_cnt_r  <= 4'h0;
      hold_done_r <= 1'b0;
      setup_cnt_r <= 4'h0;
      data_r      <= 1'b1; // (R4)
    end else if (st_r != ST_LOW) begin
      hold_cnt_r  <= 4'h0;
      hold_done_r <= 1'b0;
      setup_cnt_r <= 4'h0;
    end else if (!hold_done_r) begin
      hold_cnt_r <= hold_cnt_r + 4'h1;
      if (hold_cnt_r + 4'h1 >= hold_min) begin
        hold_done_r <= 1'b1; // (R4) (R5)
      end
    end else if (data_r != ctl_r[`SBCC_CTL_DAT_BIT]) begin
      data_r      <= ctl_r[`SBCC_CTL_DAT_BIT]; // (R6)
      setup_cnt_r <= 4'h0;
    end else if (setup_cnt_r != 4'hf) begin
      setup_cnt_r <= setup_cnt_r + 4'h1; // (R4) (R5)
    end
  end

  // open-drain drivers, low when enabled
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_scl_o  <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_o  <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
      o_scl_oe <= (st_nxt == ST_LOW); // (R15)
      o_sda_oe <= en & ctl_r[`SBCC_CTL_RUN_BIT] & ~data_r; // (R10)
    end
  end
endmodule // sbcc_top

// file: dv/sbcc_chk.sv
`timescale 1ns/100ps
module sbcc_chk (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire o_scl_oe,
  input wire o_sda_oe,
  input wire o_t3_reload,
  input wire o_t3_count,
  input wire i_slave_evt,
  input wire o_slave_irq,
  input wire o_slave_nack
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_hold; $stable(o_sda_oe)[*3]; endsequence
  sequence s_high; !o_scl_oe[*3]; endsequence
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer");
  a_bus_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer too long");
  a_timer_excl: assert property (!(o_t3_reload && o_t3_count))
    else $error("reload and count");
  a_irq_cause: assert property (o_slave_irq |-> $past(i_slave_evt))
    else $error("irq without event");
  a_irq_block: assert property (i_slave_evt && o_slave_nack |=> !o_slave_irq)
    else $error("irq while inhibited");
  a_hold_min: assert property ($rose(o_scl_oe) |-> s_hold)
    else $error("hold too short");
  a_setup_min: assert property ($fell(o_scl_oe) |-> $stable(o_sda_oe))
    else $error("setup too short");
  a_high_min: assert property ($fell(o_scl_oe) |-> s_high)
    else $error("high too short");
endmodule // sbcc_chk
bind sbcc_top sbcc_chk u_chk (.i_clk, .i_rst_n, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .o_scl_oe,
  .o_sda_oe, .o_t3_reload, .o_t3_count, .i_slave_evt, .o_slave_irq, .o_slave_nack);

// file: dv/sbcc_bus_model.sv
`timescale 1ns/100ps
module sbcc_bus_model (
  input  wire i_scl_oe,
  input  wire i_sda_oe,
  input  wire i_scl_pull,
  input  wire i_sda_pull,
  output wire o_scl,
  output wire o_sda
);
  // pull-ups: released lines read high
  assign o_scl = !(i_scl_oe || i_scl_pull);
  assign o_sda = !(i_sda_oe || i_sda_pull);
endmodule // sbcc_bus_model

// file: dv/test_sbcc_top.sv
`timescale 1ns/100ps
module test_sbcc_top;
  reg         i_clk = 0;
  reg         i_rst_n = 0;
  reg  [9:0]  adr = 0;
  reg  [7:0]  wd = 0;
  reg  [5:0]  tc = 0;
  reg  [3:0]  ovf = 0;
  reg         rd = 0, wr = 0, evt = 0, scp = 0, sdp = 0;
  reg  [31:0] q;
  wire [31:0] rdat;
  wire        wt, scl, sda, scl_oe, sda_oe, t3r, t3c, irq, nack;
  integer     mismatches = 0;
  integer     n_compared = 0;
  integer     i;
  time        t;
  always #10 i_clk = ~i_clk;
  // overflow periods 8, 16, 32, 64 clocks
  always @(posedge i_clk) begin
    tc <= tc + 6'h01;
    ovf <= {tc == 6'h3f, tc[4:0] == 5'h1f, tc[3:0] == 4'hf, tc[2:0] == 3'h7};
  end
  sbcc_bus_model u_bus (.i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_scl_pull(scp), .i_sda_pull(sdp), .o_scl(scl),
    .o_sda(sda));
  sbcc_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata({24'h0, wd}), .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_tmr_ovf(ovf), .i_scl(scl),
    .i_sda(sda), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(), .o_sda_oe(sda_oe), .o_t3_reload(t3r),
    .o_t3_count(t3c), .i_slave_evt(evt), .o_slave_irq(irq), .o_slave_nack(nack));
  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("Error %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task acc(input w, input [9:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge i_clk); while (wt !== 1'b0);
      q = rdat;
      wr <= 0;
      rd <= 0;
    end
  endtask
  task pulse(input e);
    begin
      evt <= 1;
      @(posedge i_clk);
      evt <= 0;
      @(posedge i_clk);
      chk(irq, e);
    end
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches = mismatches + 1;
    summarize;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1;
    acc(0, 10'h304, 0);
    chk(q, 32'h0);
    acc(1, 10'h304, 8'hff);
    acc(0, 10'h304, 0);
    chk(q, 32'hdf);
    acc(1, 10'h3fc, 8'hff);
    acc(0, 10'h3fc, 0);
    chk(q, 32'h0);
    acc(1, 10'h304, 8'h88);
    repeat (4) @(posedge i_clk);
    chk({t3r, t3c}, 2'b10);
    scp <= 1;
    repeat (6) @(posedge i_clk);
    chk({t3r, t3c}, 2'b01);
    acc(1, 10'h304, 8'h08);
    repeat (2) @(posedge i_clk);
    chk({t3r, t3c}, 2'b00);
    acc(1, 10'h304, 8'h88);
    repeat (2) @(posedge i_clk);
    chk({t3r, t3c}, 2'b01);
    scp <= 0;
    acc(1, 10'h304, 8'h40);
    acc(1, 10'h304, 8'hc0);
    @(posedge i_clk);
    pulse(0);
    chk(nack, 1'b1);
    acc(1, 10'h304, 8'h80);
    sdp <= 1;
    repeat (8) @(posedge i_clk);
    acc(0, 10'h304, 0);
    chk(q, 32'ha0);
    chk(nack, 1'b0);
    pulse(1);
    sdp <= 0;
    repeat (8) @(posedge i_clk);
    acc(0, 10'h304, 0);
    chk(q, 32'h80);
    acc(1, 10'h304, 8'h84);
    sdp <= 1;
    repeat (4) @(posedge i_clk);
    scp <= 1;
    repeat (4) @(posedge i_clk);
    sdp <= 0;
    repeat (4) @(posedge i_clk);
    scp <= 0;
    acc(0, 10'h304, 0);
    chk(q, 32'ha4);
    repeat (120) @(posedge i_clk);
    acc(0, 10'h304, 0);
    chk(q, 32'h84);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1, 10'h304, 8'h80 | i[7:0]);
      acc(1, 10'h308, 8'h01);
      @(posedge scl_oe);
      @(posedge scl_oe);
      t = $time;
      @(posedge scl_oe);
      chk(($time - t) >= 40 * (8 << i) && ($time - t) <= 80 * (8 << i), 1);
      @(negedge scl_oe);
      acc(1, 10'h308, 8'h00);
    end
    for (i = 0; i < 2; i = i + 1) begin
      acc(1, 10'h304, 8'h81 | (i[7:0] << 4));
      acc(1, 10'h308, 8'h01);
      @(negedge scl_oe);
      acc(1, 10'h308, 8'h03);
      @(posedge scl_oe);
      t = $time;
      @(sda_oe);
      chk(($time - t) >= (i ? 240 : 60), 1);
      t = $time;
      @(negedge scl_oe);
      chk(($time - t) >= (i ? 220 : 20), 1);
      acc(1, 10'h308, 8'h00);
    end
    summarize;
  end
endmodule // test_sbcc_top
